//--- hdl/mtlb_top.sv
`timescale 1ns/1ps
// Function
// - Every fetch and data address is a 32-bit virtual address in one 4 GB space.
// - The low 2 GB half is user space and a user access to the high half is an error.
// - The kernel half has a cached direct region and an uncached direct region.
// - The full buffer has 64 entries of 64 bits, all compared at once.
// - Each entry maps 4K to 4M pages and its size sets how many low bits pass through.
// - Fetch addresses are first looked up in a 2-entry micro buffer.
// - A fetch that misses the micro buffer is looked up in the full buffer.
// - Data addresses go straight to the full buffer.
// - Each failed translation overwrites the faulting address register, except a fetch fault in the same cycle as a data fault.
// - The page-mask register sets the page size stored with each written entry.
module mtlb_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [mtlb_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic user_mode_i,
  input wire logic if_req_i,
  input wire logic [31:0] if_vaddr_i,
  output logic if_ack_o,
  output logic [31:0] if_paddr_o,
  output logic if_uncached_o,
  output logic if_exc_o,
  input wire logic dt_req_i,
  input wire logic [31:0] dt_vaddr_i,
  output logic dt_ack_o,
  output logic [31:0] dt_paddr_o,
  output logic dt_uncached_o,
  output logic dt_exc_o,
  output logic exc_mode_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_sel(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      merge_sel[b*8 +: 8] = sel[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
    end
  endfunction

  function automatic mtlb_pkg::mtlb_xlate_s xlate(input logic [31:0] va, input logic user,
                                                  input logic hit,
                                                  input mtlb_pkg::mtlb_entry_s e);
    xlate = '0;
    if (user && va[31]) begin
      xlate.mode_err = 1'b1;
    end else if (va[31:29] == mtlb_pkg::SEG_KCACHED) begin
      xlate.paddr = va & mtlb_pkg::DIRECT_MASK;
    end else if (va[31:29] == mtlb_pkg::SEG_KUNCACHED) begin
      xlate.paddr = va & mtlb_pkg::DIRECT_MASK;
      xlate.uncached = 1'b1;
    end else if (!hit) begin
      xlate.miss = 1'b1;
    end else begin
      xlate.paddr = mtlb_pkg::compose_pa(e, va);
      xlate.uncached = !e.cached;
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] entry_hi_q, entry_hi_d, entry_lo_q, entry_lo_d, fault_va_q, fault_va_d;
  logic [31:0] wb_dat_q, wb_dat_d, if_paddr_q, if_paddr_d, dt_paddr_q, dt_paddr_d;
  logic [mtlb_pkg::PSZ_W-1:0] pmask_q, pmask_d;
  logic [mtlb_pkg::IDX_W-1:0] index_q, index_d, random_q, random_d, wired_q, wired_d;
  logic [mtlb_pkg::EV_W-1:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d;
  mtlb_pkg::mtlb_if_e if_st_q, if_st_d;
  logic irq_q, irq_d, wb_ack_q, wb_ack_d, if_ack_q, if_ack_d, if_unc_q, if_unc_d;
  logic if_exc_q, if_exc_d, dt_ack_q, dt_ack_d, dt_unc_q, dt_unc_d, dt_exc_q, dt_exc_d;
  logic mode_q, mode_d;

  logic bus_req, bus_wr, cmd_wr, tlb_wr;
  logic [mtlb_pkg::IDX_W-1:0] tlb_wr_idx;
  logic [mtlb_pkg::EV_W-1:0] ev;
  mtlb_pkg::mtlb_entry_s new_entry, rd_entry, cam_entry, micro_entry;
  logic cam_hit, micro_hit, dt_take, if_take, if_walk, micro_fill;
  logic [31:0] cam_va;
  mtlb_pkg::mtlb_xlate_s dt_res, if_res;

  // ----------------------------------------------------------------
  // lookup engines
  // ----------------------------------------------------------------
  assign dt_take = dt_req_i && !dt_ack_q;
  assign if_take = if_req_i && (if_st_q == mtlb_pkg::IF_IDLE);
  // data owns the full buffer; a walking fetch waits one cycle at most
  assign if_walk = if_req_i && (if_st_q == mtlb_pkg::IF_WALK) && !dt_take;
  assign cam_va = dt_take ? dt_vaddr_i : if_vaddr_i;
  assign micro_fill = if_walk && cam_hit && !if_res.mode_err && !if_vaddr_i[31];

  assign new_entry = '{rsvd: '0,
                       asid: entry_hi_q[mtlb_pkg::ASID_W-1:0],
                       global: entry_lo_q[mtlb_pkg::FLD_G],
                       valid: entry_lo_q[mtlb_pkg::FLD_V],
                       dirty: entry_lo_q[mtlb_pkg::FLD_D],
                       cached: entry_lo_q[mtlb_pkg::FLD_C],
                       psize: pmask_q,
                       vpn: entry_hi_q[31:mtlb_pkg::OFS_W],
                       pfn: entry_lo_q[31:mtlb_pkg::OFS_W]};

  mtlb_cam u_cam (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(tlb_wr),
    .wr_idx_i(tlb_wr_idx),
    .wr_entry_i(new_entry),
    .rd_idx_i(index_q),
    .rd_entry_o(rd_entry),
    .look_va_i(cam_va),
    .look_asid_i(entry_hi_q[mtlb_pkg::ASID_W-1:0]),
    .hit_o(cam_hit),
    .hit_entry_o(cam_entry)
  );

  // stale micro entries are dropped on any buffer write or bus write to OFS_ENTRY_HI; a read-back asid change keeps them
  mtlb_micro u_micro (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(tlb_wr || (bus_wr && wb_adr_i == mtlb_pkg::OFS_ENTRY_HI)),
    .fill_i(micro_fill),
    .fill_entry_i(cam_entry),
    .va_i(if_vaddr_i),
    .asid_i(entry_hi_q[mtlb_pkg::ASID_W-1:0]),
    .hit_o(micro_hit),
    .entry_o(micro_entry)
  );

  assign dt_res = xlate(dt_vaddr_i, user_mode_i, cam_hit, cam_entry);
  assign if_res = (if_st_q == mtlb_pkg::IF_WALK) ?
      xlate(if_vaddr_i, user_mode_i, cam_hit, cam_entry) :
      xlate(if_vaddr_i, user_mode_i, micro_hit, micro_entry);

  // ----------------------------------------------------------------
  // pipeline answers
  // ----------------------------------------------------------------
  always_comb begin
    if_st_d = if_st_q;
    if_ack_d = 1'b0;
    if_paddr_d = if_paddr_q;
    if_unc_d = if_unc_q;
    if_exc_d = 1'b0;
    dt_ack_d = dt_take;
    dt_paddr_d = dt_paddr_q;
    dt_unc_d = dt_unc_q;
    dt_exc_d = 1'b0;
    ev = '0;
    if (dt_take) begin
      dt_paddr_d = dt_res.paddr;
      dt_unc_d = dt_res.uncached;
      dt_exc_d = dt_res.miss || dt_res.mode_err;
      ev[mtlb_pkg::EV_DATA] = dt_res.miss;
      ev[mtlb_pkg::EV_MODE] = dt_res.mode_err;
    end
    case (if_st_q)
      mtlb_pkg::IF_IDLE: begin
        if (if_take) begin
          if_st_d = if_res.miss ? mtlb_pkg::IF_WALK : mtlb_pkg::IF_DONE;
        end
      end
      mtlb_pkg::IF_WALK: begin
        if (!if_req_i || if_walk) begin
          if_st_d = if_req_i ? mtlb_pkg::IF_DONE : mtlb_pkg::IF_IDLE;
        end
      end
      mtlb_pkg::IF_DONE: if_st_d = mtlb_pkg::IF_IDLE;
      default: if_st_d = mtlb_pkg::IF_IDLE;
    endcase
    if ((if_take && !if_res.miss) || if_walk) begin
      if_ack_d = 1'b1;
      if_paddr_d = if_res.paddr;
      if_unc_d = if_res.uncached;
      if_exc_d = if_res.miss || if_res.mode_err;
      ev[mtlb_pkg::EV_IFETCH] = if_res.miss;
      ev[mtlb_pkg::EV_MODE] = ev[mtlb_pkg::EV_MODE] | if_res.mode_err;
    end
    mode_d = (dt_take && dt_res.mode_err) || (if_ack_d && if_res.mode_err);
  end

  // ----------------------------------------------------------------
  // register file and bus
  // ----------------------------------------------------------------
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_q;
  assign bus_wr = bus_req && wb_we_i;
  assign cmd_wr = bus_wr && (wb_adr_i == mtlb_pkg::OFS_CMD) && wb_sel_i[0];
  assign tlb_wr = cmd_wr && (wb_dat_i[mtlb_pkg::CMD_WR_IDX] || wb_dat_i[mtlb_pkg::CMD_WR_RND]);
  assign tlb_wr_idx = wb_dat_i[mtlb_pkg::CMD_WR_RND] ? random_q : index_q;

  always_comb begin
    entry_hi_d = entry_hi_q;
    entry_lo_d = entry_lo_q;
    pmask_d = pmask_q;
    index_d = index_q;
    wired_d = wired_q;
    irq_mask_d = irq_mask_q;
    irq_stat_d = irq_stat_q;
    wb_ack_d = bus_req;
    wb_dat_d = '0;
    if (bus_wr) begin
      case (wb_adr_i)
        mtlb_pkg::OFS_ENTRY_HI: entry_hi_d = merge_sel(entry_hi_q, wb_dat_i, wb_sel_i);
        mtlb_pkg::OFS_ENTRY_LO: entry_lo_d = merge_sel(entry_lo_q, wb_dat_i, wb_sel_i);
        default: entry_hi_d = entry_hi_q;
      endcase
    end
    if (bus_wr && wb_sel_i[0]) begin
      case (wb_adr_i)
        mtlb_pkg::OFS_PAGE_MASK: pmask_d = wb_dat_i[mtlb_pkg::PSZ_W-1:0];
        mtlb_pkg::OFS_INDEX: index_d = wb_dat_i[mtlb_pkg::IDX_W-1:0];
        mtlb_pkg::OFS_WIRED: wired_d = wb_dat_i[mtlb_pkg::IDX_W-1:0];
        mtlb_pkg::OFS_IRQ_STAT: irq_stat_d = irq_stat_q & ~wb_dat_i[mtlb_pkg::EV_W-1:0];
        mtlb_pkg::OFS_IRQ_MASK: irq_mask_d = wb_dat_i[mtlb_pkg::EV_W-1:0];
        default: index_d = index_q;
      endcase
    end
    // read-back loads the holding registers from the indexed entry
    if (cmd_wr && wb_dat_i[mtlb_pkg::CMD_RD_IDX]) begin
      entry_hi_d = {rd_entry.vpn, 4'h0, rd_entry.asid};
      entry_lo_d = {rd_entry.pfn, 8'h00, rd_entry.cached, rd_entry.dirty,
                    rd_entry.valid, rd_entry.global};
      pmask_d = rd_entry.psize;
    end
    irq_stat_d = irq_stat_d | ev; // set wins over clear
    if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        mtlb_pkg::OFS_ENTRY_HI: wb_dat_d = entry_hi_q;
        mtlb_pkg::OFS_ENTRY_LO: wb_dat_d = entry_lo_q;
        mtlb_pkg::OFS_PAGE_MASK: wb_dat_d = {29'h0, pmask_q};
        mtlb_pkg::OFS_INDEX: wb_dat_d = {26'h0, index_q};
        mtlb_pkg::OFS_RANDOM: wb_dat_d = {26'h0, random_q};
        mtlb_pkg::OFS_WIRED: wb_dat_d = {26'h0, wired_q};
        mtlb_pkg::OFS_FAULT_VA: wb_dat_d = fault_va_q;
        mtlb_pkg::OFS_IRQ_STAT: wb_dat_d = {29'h0, irq_stat_q};
        mtlb_pkg::OFS_IRQ_MASK: wb_dat_d = {29'h0, irq_mask_q};
        mtlb_pkg::OFS_REV_ID: wb_dat_d = mtlb_pkg::REV_ID_VAL;
        default: wb_dat_d = '0;
      endcase
    end
    irq_d = |(irq_stat_q & irq_mask_q);
  end

  // random walks down from the top and wraps before crossing wired
  always_comb begin
    if (bus_wr && wb_adr_i == mtlb_pkg::OFS_WIRED && wb_sel_i[0]) begin
      random_d = mtlb_pkg::RANDOM_TOP;
    end else if (random_q <= wired_q) begin
      random_d = mtlb_pkg::RANDOM_TOP;
    end else begin
      random_d = random_q - mtlb_pkg::IDX_ONE;
    end
  end

  // data fault is the earlier one in program order, so it wins a tie
  always_comb begin
    fault_va_d = fault_va_q;
    if (dt_take && dt_exc_d) begin
      fault_va_d = dt_vaddr_i;
    end else if (if_ack_d && if_exc_d) begin
      fault_va_d = if_vaddr_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      entry_hi_q <= '0;
      entry_lo_q <= '0;
      pmask_q <= mtlb_pkg::PSZ_4K;
      index_q <= '0;
      random_q <= mtlb_pkg::RANDOM_TOP;
      wired_q <= '0;
      fault_va_q <= '0;
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      irq_q <= 1'b0;
      wb_ack_q <= 1'b0;
      wb_dat_q <= '0;
      if_st_q <= mtlb_pkg::IF_IDLE;
      if_ack_q <= 1'b0;
      if_paddr_q <= '0;
      if_unc_q <= 1'b0;
      if_exc_q <= 1'b0;
      dt_ack_q <= 1'b0;
      dt_paddr_q <= '0;
      dt_unc_q <= 1'b0;
      dt_exc_q <= 1'b0;
      mode_q <= 1'b0;
    end else begin
      entry_hi_q <= entry_hi_d;
      entry_lo_q <= entry_lo_d;
      pmask_q <= pmask_d;
      index_q <= index_d;
      random_q <= random_d;
      wired_q <= wired_d;
      fault_va_q <= fault_va_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q <= irq_d;
      wb_ack_q <= wb_ack_d;
      wb_dat_q <= wb_dat_d;
      if_st_q <= if_st_d;
      if_ack_q <= if_ack_d;
      if_paddr_q <= if_paddr_d;
      if_unc_q <= if_unc_d;
      if_exc_q <= if_exc_d;
      dt_ack_q <= dt_ack_d;
      dt_paddr_q <= dt_paddr_d;
      dt_unc_q <= dt_unc_d;
      dt_exc_q <= dt_exc_d;
      mode_q <= mode_d;
    end
  end

  assign {wb_ack_o, irq_o, exc_mode_o} = {wb_ack_q, irq_q, mode_q};
  assign {wb_dat_o, if_paddr_o, dt_paddr_o} = {wb_dat_q, if_paddr_q, dt_paddr_q};
  assign {if_ack_o, if_uncached_o, if_exc_o} = {if_ack_q, if_unc_q, if_exc_q};
  assign {dt_ack_o, dt_uncached_o, dt_exc_o} = {dt_ack_q, dt_unc_q, dt_exc_q};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence dt_user_high;
    dt_take && user_mode_i && dt_vaddr_i[31];
  endsequence
  sequence if_miss_start;
    if_take && if_res.miss;
  endsequence

  user_kernel_err_a: assert property (dt_user_high |=> dt_exc_o && exc_mode_o)
    else $error("user access to kernel half not flagged");
  uncached_seg_a: assert property (dt_take && !user_mode_i &&
      dt_vaddr_i[31:29] == mtlb_pkg::SEG_KUNCACHED |=> dt_uncached_o && !dt_exc_o)
    else $error("uncached segment misclassified");
  data_direct_a: assert property (dt_take |=> dt_ack_o ##1 !dt_ack_o)
    else $error("data answer not in one cycle");
  micro_hit_a: assert property (if_take && micro_hit && !if_vaddr_i[31]
      |=> if_ack_o && !if_exc_o)
    else $error("micro hit not answered next cycle");
  walk_bound_a: assert property (if_miss_start ##1 if_req_i[*2] |-> ##[0:1] if_ack_o)
    else $error("fetch walk took too long");
  page_offset_a: assert property (dt_take && !dt_res.miss && !dt_res.mode_err
      |=> dt_paddr_o[mtlb_pkg::OFS_W-1:0] == $past(dt_vaddr_i[mtlb_pkg::OFS_W-1:0]))
    else $error("page offset not passed through");
  fault_capture_a: assert property (dt_take && dt_res.miss
      |=> fault_va_q == $past(dt_vaddr_i) && irq_stat_q[mtlb_pkg::EV_DATA])
    else $error("fault address not captured");
  random_floor_a: assert property (random_q >= wired_q)
    else $error("random below wired");
  fetch_exc_a: assert property (if_walk && !cam_hit && !if_vaddr_i[31]
      |=> if_exc_o && !dt_exc_o && irq_stat_q[mtlb_pkg::EV_IFETCH])
    else $error("fetch miss not raised");

endmodule // mtlb_top

//--- hdl/mtlb_pkg.sv
package mtlb_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned ENTRIES = 64;
  localparam int unsigned MICRO_N = 2;
  localparam int unsigned IDX_W = 6;
  localparam int unsigned VPN_W = 20;
  localparam int unsigned OFS_W = 12;
  localparam int unsigned ASID_W = 8;
  localparam int unsigned PSZ_W = 3;
  localparam int unsigned ADR_W = 8;
  localparam int unsigned EV_W = 3;
  localparam logic [IDX_W-1:0] RANDOM_TOP = 6'h3F;
  localparam logic [IDX_W-1:0] IDX_ONE = 6'h01;

  // ----------------------------------------------------------------
  // register map, byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADR_W-1:0] OFS_ENTRY_HI = 8'h00;
  localparam logic [ADR_W-1:0] OFS_ENTRY_LO = 8'h04;
  localparam logic [ADR_W-1:0] OFS_PAGE_MASK = 8'h08;
  localparam logic [ADR_W-1:0] OFS_INDEX = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_RANDOM = 8'h10;
  localparam logic [ADR_W-1:0] OFS_WIRED = 8'h14;
  localparam logic [ADR_W-1:0] OFS_FAULT_VA = 8'h18;
  localparam logic [ADR_W-1:0] OFS_CMD = 8'h1C;
  localparam logic [ADR_W-1:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [ADR_W-1:0] OFS_IRQ_MASK = 8'h24;
  localparam logic [ADR_W-1:0] OFS_REV_ID = 8'h28;
  // arbitrary value, not tied to any part
  localparam logic [31:0] REV_ID_VAL = 32'h0000_0A51;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned FLD_G = 0;
  localparam int unsigned FLD_V = 1;
  localparam int unsigned FLD_D = 2;
  localparam int unsigned FLD_C = 3;
  localparam int unsigned CMD_WR_IDX = 0;
  localparam int unsigned CMD_WR_RND = 1;
  localparam int unsigned CMD_RD_IDX = 2;
  localparam int unsigned EV_IFETCH = 0;
  localparam int unsigned EV_DATA = 1;
  localparam int unsigned EV_MODE = 2;

  localparam logic [PSZ_W-1:0] PSZ_4K = 3'h0;
  localparam logic [PSZ_W-1:0] PSZ_16K = 3'h1;
  localparam logic [PSZ_W-1:0] PSZ_64K = 3'h2;
  localparam logic [PSZ_W-1:0] PSZ_256K = 3'h3;
  localparam logic [PSZ_W-1:0] PSZ_1M = 3'h4;
  localparam logic [PSZ_W-1:0] PSZ_4M = 3'h5;

  // ----------------------------------------------------------------
  // address segments
  // ----------------------------------------------------------------
  localparam logic [2:0] SEG_KCACHED = 3'h4;
  localparam logic [2:0] SEG_KUNCACHED = 3'h5;
  localparam logic [31:0] DIRECT_MASK = 32'h1FFF_FFFF;

  typedef struct packed {
    logic [8:0] rsvd;
    logic [ASID_W-1:0] asid;
    logic global;
    logic valid;
    logic dirty;
    logic cached;
    logic [PSZ_W-1:0] psize;
    logic [VPN_W-1:0] vpn;
    logic [VPN_W-1:0] pfn;
  } mtlb_entry_s;

  typedef struct packed {
    logic mode_err;
    logic miss;
    logic uncached;
    logic [31:0] paddr;
  } mtlb_xlate_s;

  typedef enum logic [1:0] {
    IF_IDLE = 2'b00,
    IF_WALK = 2'b01,
    IF_DONE = 2'b11
  } mtlb_if_e;

  // vpn bits ignored by the compare for each page size
  function automatic logic [VPN_W-1:0] page_mask(input logic [PSZ_W-1:0] psize);
    case (psize)
      PSZ_16K: page_mask = 20'h00003;
      PSZ_64K: page_mask = 20'h0000F;
      PSZ_256K: page_mask = 20'h0003F;
      PSZ_1M: page_mask = 20'h000FF;
      PSZ_4M: page_mask = 20'h003FF;
      default: page_mask = 20'h00000;
    endcase
  endfunction

  function automatic logic vpn_match(input mtlb_entry_s e, input logic [31:0] va,
                                     input logic [ASID_W-1:0] asid);
    logic [VPN_W-1:0] m;
    m = page_mask(e.psize);
    vpn_match = e.valid && (((e.vpn ^ va[31:OFS_W]) & ~m) == '0) &&
                (e.global || (e.asid == asid));
  endfunction

  function automatic logic [31:0] compose_pa(input mtlb_entry_s e, input logic [31:0] va);
    logic [VPN_W-1:0] m;
    m = page_mask(e.psize);
    compose_pa = {(e.pfn & ~m) | (va[31:OFS_W] & m), va[OFS_W-1:0]};
  endfunction

endpackage

//--- hdl/mtlb_cam.sv
`timescale 1ns/1ps
module mtlb_cam (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [mtlb_pkg::IDX_W-1:0] wr_idx_i,
  input mtlb_pkg::mtlb_entry_s wr_entry_i,
  input wire logic [mtlb_pkg::IDX_W-1:0] rd_idx_i,
  output mtlb_pkg::mtlb_entry_s rd_entry_o,
  input wire logic [31:0] look_va_i,
  input wire logic [mtlb_pkg::ASID_W-1:0] look_asid_i,
  output logic hit_o,
  output mtlb_pkg::mtlb_entry_s hit_entry_o
);

  mtlb_pkg::mtlb_entry_s mem_q [mtlb_pkg::ENTRIES];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < mtlb_pkg::ENTRIES; i++) begin
        mem_q[i] <= '0;
      end
    end else if (wr_en_i) begin
      mem_q[wr_idx_i] <= wr_entry_i;
    end
  end

  assign rd_entry_o = mem_q[rd_idx_i];

  // every entry compared at once; lowest index wins on overlap
  always_comb begin
    hit_o = 1'b0;
    hit_entry_o = '0;
    for (int i = mtlb_pkg::ENTRIES - 1; i >= 0; i--) begin
      if (mtlb_pkg::vpn_match(mem_q[i], look_va_i, look_asid_i)) begin
        hit_o = 1'b1;
        hit_entry_o = mem_q[i];
      end
    end
  end

endmodule // mtlb_cam

//--- hdl/mtlb_micro.sv
`timescale 1ns/1ps
module mtlb_micro (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  input wire logic fill_i,
  input mtlb_pkg::mtlb_entry_s fill_entry_i,
  input wire logic [31:0] va_i,
  input wire logic [mtlb_pkg::ASID_W-1:0] asid_i,
  output logic hit_o,
  output mtlb_pkg::mtlb_entry_s entry_o
);

  mtlb_pkg::mtlb_entry_s slot_q [mtlb_pkg::MICRO_N];
  mtlb_pkg::mtlb_entry_s slot_d [mtlb_pkg::MICRO_N];
  logic victim_q;
  logic victim_d;

  always_comb begin
    slot_d = slot_q;
    victim_d = victim_q;
    if (flush_i) begin
      slot_d[0] = '0;
      slot_d[1] = '0;
      victim_d = 1'b0;
    end else if (fill_i) begin
      slot_d[victim_q] = fill_entry_i;
      victim_d = ~victim_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slot_q[0] <= '0;
      slot_q[1] <= '0;
      victim_q <= 1'b0;
    end else begin
      slot_q <= slot_d;
      victim_q <= victim_d;
    end
  end

  always_comb begin
    hit_o = 1'b0;
    entry_o = '0;
    for (int i = 0; i < mtlb_pkg::MICRO_N; i++) begin
      if (!hit_o && mtlb_pkg::vpn_match(slot_q[i], va_i, asid_i)) begin
        hit_o = 1'b1;
        entry_o = slot_q[i];
      end
    end
  end

endmodule // mtlb_micro

//--- dv/mtlb_pipe_model.sv
`timescale 1ns/1ps
// stand-in pipeline: holds one request until its ack
module mtlb_pipe_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [31:0] va_i,
  input wire logic ack_i,
  output logic req_o,
  output logic [31:0] va_o
);
  initial begin
    req_o = 1'b0;
    va_o = 32'h0;
  end
  always @(posedge clk_i) begin
    if (go_i) begin
      req_o <= 1'b1;
      va_o <= va_i;
    end else if (ack_i) begin
      req_o <= 1'b0;
      // scrambled so nothing leans on a released address
      va_o <= ~va_o;
    end
  end
endmodule // mtlb_pipe_model

//--- dv/mtlb_top_tb_top.sv
`timescale 1ns/1ps
module mtlb_top_tb_top;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_we_i = 0, user_mode_i = 0, ifg = 0, dtg = 0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, if_vaddr_i, if_paddr_o, dt_vaddr_i, dt_paddr_o;
  logic [31:0] va = 32'h0, base, pfn, off, r;
  logic wb_ack_o, if_req_i, if_ack_o, if_uncached_o, if_exc_o, dt_req_i, dt_ack_o;
  logic dt_uncached_o, dt_exc_o, exc_mode_o, irq_o;
  logic [34:0] q[$];
  int err_count = 0, comparisons = 0, cyc_n = 0;
  always #12.5 clk_i = ~clk_i;
  mtlb_top dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i(wb_cyc_i), .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .user_mode_i, .if_req_i, .if_vaddr_i,
    .if_ack_o, .if_paddr_o, .if_uncached_o, .if_exc_o, .dt_req_i, .dt_vaddr_i, .dt_ack_o,
    .dt_paddr_o, .dt_uncached_o, .dt_exc_o, .exc_mode_o, .irq_o);
  mtlb_pipe_model fetch_side (.clk_i, .go_i(ifg), .va_i(va), .ack_i(if_ack_o),
    .req_o(if_req_i), .va_o(if_vaddr_i));
  mtlb_pipe_model data_side (.clk_i, .go_i(dtg), .va_i(va), .ack_i(dt_ack_o),
    .req_o(dt_req_i), .va_o(dt_vaddr_i));
  // ----
  // tasks
  // ----
  task automatic chk(input logic [34:0] g, input logic [34:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic close_out;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] rd_o);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd_o = wb_dat_o;
    wb_cyc_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    q.push_back({3'h0, e});
    wb(1'b0, a, 32'h0, x);
  endtask
  // fetch or data lookup; expectation is {mode, exc, uncached, paddr}
  task automatic lk(input logic f, input logic [31:0] v, input logic [34:0] e);
    q.push_back(e);
    va <= v;
    if (f) ifg <= 1'b1;
    else dtg <= 1'b1;
    @(posedge clk_i);
    ifg <= 1'b0;
    dtg <= 1'b0;
    @(posedge clk_i iff (if_ack_o | dt_ack_o));
    @(posedge clk_i);
  endtask
  // ----
  // monitor and timeout
  // ----
  always @(posedge clk_i) begin : mon
    logic [34:0] g;
    logic [34:0] e;
    if (wb_ack_o === 1'b1 && !wb_we_i && q.size() > 0) chk({3'h0, wb_dat_o}, q.pop_front());
    else if ((if_ack_o | dt_ack_o) === 1'b1) begin
      e = q.pop_front();
      g = if_ack_o ? {exc_mode_o, if_exc_o, if_uncached_o, if_paddr_o}
                   : {exc_mode_o, dt_exc_o, dt_uncached_o, dt_paddr_o};
      // address is don't-care on a fault
      if (e[33]) g[32:0] = e[32:0];
      chk(g, e);
    end
    cyc_n++;
    if (cyc_n > 3000) begin
      err_count++;
      close_out;
    end
  end
  initial begin
    void'($urandom(7));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h28, 32'h0000_0A51);
    rd(8'h3C, 32'h0);
    wb(1'b1, 8'h24, 32'h7, r);
    user_mode_i <= 1'b1;
    lk(1'b0, 32'h8000_1000, {2'h3, 33'h0});
    user_mode_i <= 1'b0;
    rd(8'h20, 32'h4);
    chk({34'h0, irq_o}, 35'h1);
    wb(1'b1, 8'h20, 32'h4, r);
    rd(8'h20, 32'h0);
    chk({34'h0, irq_o}, 35'h0);
    lk(1'b0, 32'h8123_4560, {3'h0, 32'h0123_4560});
    lk(1'b1, 32'hA000_0040, {3'h1, 32'h0000_0040});
    lk(1'b0, 32'hB000_0080, {3'h1, 32'h1000_0080});
    base = {1'b0, 9'($urandom), 22'h0};
    pfn = {10'($urandom), 22'h0};
    off = {10'h0, 22'($urandom)};
    wb(1'b1, 8'h00, base, r);
    wb(1'b1, 8'h04, {pfn[31:12], 12'h00B}, r);
    wb(1'b1, 8'h08, 32'h5, r);
    wb(1'b1, 8'h0C, 32'h3F, r);
    wb(1'b1, 8'h1C, 32'h1, r);
    lk(1'b0, base | off, {3'h0, pfn | off});
    repeat (2) lk(1'b1, base | off, {3'h0, pfn | off});
    lk(1'b0, base ^ 32'h0040_0000, {2'h1, 33'h0});
    lk(1'b1, base ^ 32'h0040_0000, {2'h1, 33'h0});
    rd(8'h18, base ^ 32'h0040_0000);
    wb(1'b1, 8'h08, 32'h0, r);
    wb(1'b1, 8'h1C, 32'h4, r);
    rd(8'h08, 32'h5);
    wb(1'b1, 8'h14, 32'h3E, r);
    repeat (4) begin
      wb(1'b0, 8'h10, 32'h0, r);
      chk({34'h0, r >= 32'h3E}, 35'h1);
    end
    close_out;
  end
endmodule // mtlb_top_tb_top
